// file: core/sfs_pkg.sv
`default_nettype none
package sfs_pkg;
  // ----------------------------------------
  // frame layout
  // ----------------------------------------
  localparam int ADDR_BITS = 16;
  localparam int CTRL_BITS = 8;
  localparam int HDR_BITS = 24;
  localparam int BYTE_BITS = 8;
  localparam logic [1:0] LEN_VAR = 2'h0;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_FOUR = 2'h3;
  localparam logic RW_WRITE = 1'b1;
  localparam logic RW_READ = 1'b0;
  // control byte field positions
  localparam int CTRL_BSEL_LSB = 3;
  localparam int CTRL_RW_POS = 2;
  localparam int CTRL_LEN_LSB = 0;
  // ----------------------------------------
  // reset values and link timing
  // ----------------------------------------
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int CLK_MHZ = 125;
  localparam int SCLK_NS = 160;
  localparam int HALF_CYC = (SCLK_NS * CLK_MHZ / 1000) / 2;
  localparam logic [7:0] HALF_CYC_W = 8'(HALF_CYC);
  localparam logic [7:0] CS_GAP_CYC = 8'h10;

  function automatic logic [2:0] sfs_len_bytes(input logic [1:0] mode);
    sfs_len_bytes = (mode == LEN_ONE) ? 3'h1 : (mode == LEN_TWO) ? 3'h2 :
                    (mode == LEN_FOUR) ? 3'h4 : 3'h0;
  endfunction : sfs_len_bytes
endpackage : sfs_pkg
`default_nettype wire

// file: core/sfs_link_if.sv
`default_nettype none
interface sfs_link_if;
  logic sclk;
  logic chip_select_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  modport target (input sclk, input chip_select_n, input mosi, output miso, output miso_oe);
  modport host (output sclk, output chip_select_n, output mosi, input miso, input miso_oe);
endinterface : sfs_link_if
`default_nettype wire

// file: core/sfs_target.sv
// Behaviour
// - variable-length data lasts while select low
// - host sends length bits 00 for variable
// - select edges start/end frame, parser resets
// - read_write_bit 1 means write data accepted
// - read_write_bit 0 means device returns data
// - host shifts mosi on sclk falling edge
// - device shifts miso on sclk falling edge
// - extra bytes go to successive addresses
// - fixed-length mode: select tied low
// - fixed length from length bits: 1,2,4
// - write encodings 01,10,11 give 1,2,4
// - read encodings give same byte counts
// - 16 address, 5 block, rw, 2 length, data
// - host clocks exactly declared byte count
// - same bit signalling in both modes
// - bytes go msb first
`default_nettype none
module sfs_target (
  input wire logic clk,
  input wire logic rst,
  sfs_link_if.target link,
  output logic [15:0] acc_addr,
  output logic [4:0] block_select_bits,
  output logic [7:0] wr_data,
  output logic wr_strobe,
  output logic rd_strobe,
  input wire logic [7:0] rd_data
);
  // ----------------------------------------
  // synchronisers and edge detection
  // ----------------------------------------
  logic [1:0] sclk_s, cs_s, mosi_s;
  logic sclk_d, cs_d;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_s <= 2'h0;
      cs_s <= 2'h3;
      mosi_s <= 2'h0;
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end
    else
    begin
      sclk_s <= {sclk_s[0], link.sclk};
      cs_s <= {cs_s[0], link.chip_select_n};
      mosi_s <= {mosi_s[0], link.mosi};
      sclk_d <= sclk_s[1];
      cs_d <= cs_s[1];
    end
  end
  wire sclk_rise = sclk_s[1] & ~sclk_d;
  wire sclk_fall = ~sclk_s[1] & sclk_d;
  wire cs_low = ~cs_s[1];
  wire cs_edge = cs_s[1] ^ cs_d;

  // ----------------------------------------
  // frame parser
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_HDR = 3'b001,
    ST_DATA = 3'b010,
    ST_IDLE = 3'b100
  } sfs_state_t;
  sfs_state_t state, next_state;
  logic [4:0] bit_cnt;
  logic [23:0] hdr;
  logic [7:0] rx_sh, tx_sh;
  logic [2:0] bytes_left;
  logic fixed, rw, rd_load;
  logic miso_q, oe_q;

  wire [23:0] hdr_next = {hdr[22:0], mosi_s[1]};
  wire hdr_done = sclk_rise & (state == ST_HDR) & (bit_cnt == 5'(sfs_pkg::HDR_BITS - 1));
  wire byte_done = sclk_rise & (state == ST_DATA) & (bit_cnt == 5'(sfs_pkg::BYTE_BITS - 1));
  wire [1:0] len_f = hdr_next[sfs_pkg::CTRL_LEN_LSB +: 2];
  wire rw_f = hdr_next[sfs_pkg::CTRL_RW_POS];
  wire [2:0] len_n = sfs_pkg::sfs_len_bytes(len_f);
  wire fixed_n = (len_f != sfs_pkg::LEN_VAR);
  wire last_fixed = byte_done & fixed & (bytes_left == 3'h1);
  // both modes run whenever select is low; neither waits for a fall
  wire active = cs_low;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = active ? ST_HDR : ST_IDLE;
      ST_HDR: next_state = hdr_done ? ST_DATA : ST_HDR;
      ST_DATA: next_state = last_fixed ? ST_HDR : ST_DATA;
      default: next_state = ST_IDLE;
    endcase
    if (cs_edge | ~active)
      next_state = active ? ST_HDR : ST_IDLE;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      bit_cnt <= 5'h00;
      hdr <= 24'h00_0000;
      rx_sh <= sfs_pkg::RST_BYTE;
      tx_sh <= sfs_pkg::RST_BYTE;
      bytes_left <= 3'h0;
      fixed <= 1'b0;
      rw <= 1'b0;
      rd_load <= 1'b0;
      acc_addr <= sfs_pkg::RST_ADDR;
      block_select_bits <= 5'h00;
      wr_data <= sfs_pkg::RST_BYTE;
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      miso_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      state <= next_state;
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      rd_load <= rd_strobe;
      // write address moves on only after the strobe has shown it
      if (wr_strobe)
        acc_addr <= acc_addr + 16'h0001;
      if (next_state != state || cs_edge)
        bit_cnt <= 5'h00;
      else if (hdr_done || byte_done)
        bit_cnt <= 5'h00;
      else if (sclk_rise && state != ST_IDLE)
        bit_cnt <= bit_cnt + 5'h01;
      if (sclk_rise && state == ST_HDR)
        hdr <= hdr_next;
      if (hdr_done)
      begin
        acc_addr <= hdr_next[23:8];
        block_select_bits <= hdr_next[7:3];
        rw <= rw_f;
        fixed <= fixed_n;
        bytes_left <= len_n;
        rd_strobe <= (rw_f == sfs_pkg::RW_READ);
      end
      if (sclk_rise && state == ST_DATA)
        rx_sh <= {rx_sh[6:0], mosi_s[1]};
      if (byte_done)
      begin
        bytes_left <= bytes_left - 3'h1;
        if (rw == sfs_pkg::RW_WRITE)
        begin
          wr_data <= {rx_sh[6:0], mosi_s[1]};
          wr_strobe <= 1'b1;
        end
        if (rw == sfs_pkg::RW_READ)
          acc_addr <= acc_addr + 16'h0001;
        if (rw == sfs_pkg::RW_READ && !last_fixed)
          rd_strobe <= 1'b1;
      end
      // read data stands the cycle after its strobe, bit 7 first out
      if (rd_load)
        tx_sh <= rd_data;
      // shifted on falling sclk so it settles before host samples
      if (state == ST_DATA && rw == sfs_pkg::RW_READ)
      begin
        oe_q <= 1'b1;
        if (sclk_fall)
        begin
          miso_q <= tx_sh[7];
          tx_sh <= {tx_sh[6:0], 1'b0};
        end
      end
      else
      begin
        oe_q <= 1'b0;
        miso_q <= 1'b0;
      end
    end
  end
  assign link.miso = miso_q;
  assign link.miso_oe = oe_q;
endmodule : sfs_target
`default_nettype wire

// file: core/sfs_host.sv
`default_nettype none
module sfs_host (
  input wire logic clk,
  input wire logic rst,
  sfs_link_if.host link,
  input wire logic start,
  input wire logic [15:0] addr,
  input wire logic [4:0] block_select_bits,
  input wire logic read_write_bit,
  input wire logic [1:0] length_mode_bits,
  input wire logic [2:0] var_bytes,
  input wire logic [7:0] tx_data,
  output logic tx_take,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic busy
);
  // ----------------------------------------
  // sclk divider and shifter
  // ----------------------------------------
  logic [7:0] div;
  logic [31:0] sh;
  logic [5:0] bits_left;
  logic [2:0] bit_in_byte;
  logic [1:0] mode;
  logic [7:0] rx_sh;
  logic [1:0] miso_s;
  logic sclk_q, cs_q, rw;
  wire tick = (div == sfs_pkg::HALF_CYC_W - 8'h01);
  wire [5:0] total = 6'(sfs_pkg::HDR_BITS) + {(length_mode_bits == sfs_pkg::LEN_VAR ?
                     var_bytes : sfs_pkg::sfs_len_bytes(length_mode_bits)), 3'h0};
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div <= 8'h00;
      sh <= 32'h0000_0000;
      bits_left <= 6'h00;
      bit_in_byte <= 3'h0;
      mode <= 2'h0;
      rx_sh <= 8'h00;
      miso_s <= 2'h0;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      rw <= 1'b0;
      busy <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      tx_take <= 1'b0;
    end
    else
    begin
      miso_s <= {miso_s[0], link.miso};
      rx_valid <= 1'b0;
      tx_take <= 1'b0;
      div <= (tick || !busy) ? 8'h00 : div + 8'h01;
      if (!busy && start)
      begin
        busy <= 1'b1;
        bits_left <= total;
        mode <= length_mode_bits;
        rw <= read_write_bit;
        sh <= {addr, block_select_bits, read_write_bit, length_mode_bits};
        bit_in_byte <= 3'h0;
        cs_q <= 1'b0;
      end
      else if (busy && tick)
      begin
        if (bits_left == 6'h00)
        begin
          busy <= 1'b0;
          cs_q <= 1'b1;
          if (mode != sfs_pkg::LEN_VAR)
            cs_q <= 1'b0;
        end
        else if (!sclk_q)
        begin
          // miso sampled on rising sclk, data phase only
          sclk_q <= 1'b1;
          if (bits_left <= total - 6'(sfs_pkg::HDR_BITS))
          begin
            rx_sh <= {rx_sh[6:0], miso_s[1]};
            bit_in_byte <= bit_in_byte + 3'h1;
            if (bit_in_byte == 3'h7)
            begin
              rx_data <= {rx_sh[6:0], miso_s[1]};
              rx_valid <= ~rw;
            end
          end
        end
        else
        begin
          // mosi changes on falling edge; msb first
          sclk_q <= 1'b0;
          bits_left <= bits_left - 6'h01;
          sh <= {sh[30:0], 1'b0};
          // next byte loads only after the header or a whole data byte
          if (bits_left[2:0] == 3'h1 && bits_left > 6'h01 &&
              bits_left <= total - 6'(sfs_pkg::HDR_BITS) + 6'h01)
          begin
            sh <= {tx_data, 24'h00_0000};
            tx_take <= 1'b1;
          end
        end
      end
    end
  end
  assign link.sclk = sclk_q;
  assign link.chip_select_n = cs_q;
  // header bits sit at the top of a 24-bit window, data byte at the top
  assign link.mosi = (bits_left > 6'h08 && bits_left > total - 6'(sfs_pkg::HDR_BITS)) ?
                     sh[23] : sh[31];
endmodule : sfs_host
`default_nettype wire

// file: tb/sfs_link_props.sv
`default_nettype none
module sfs_link_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_q;
  logic [15:0] bit_cnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ------------------------------
  // sclk rises inside one selection
  // ------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_q <= 1'b0;
      bit_cnt <= 16'h0000;
    end
    else
    begin
      sclk_q <= sclk;
      bit_cnt <= chip_select_n ? 16'h0000 : bit_cnt + {15'h0000, sclk & ~sclk_q};
    end
  end
  property p_mosi_hold;
    sclk && $past(sclk) |-> $stable(mosi);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved, sclk high");
  property p_miso_hold;
    sclk && $past(sclk) && miso_oe && $past(miso_oe) |-> $stable(miso);
  endproperty
  a_miso_hold: assert property (p_miso_hold) else $error("miso moved, sclk high");
  property p_sclk_idle;
    chip_select_n |-> !sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk outside frame");
  property p_oe_off;
    chip_select_n [*6] |-> !miso_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("miso driven, deselected");
  property p_sclk_high;
    $rose(sclk) |-> sclk [*8];
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("sclk high too short");
  property p_cs_setup;
    $fell(chip_select_n) |-> !sclk [*2];
  endproperty
  a_cs_setup: assert property (p_cs_setup) else $error("sclk too soon");
  property p_frame_len;
    $rose(chip_select_n) |-> bit_cnt >= 16'h0018 && bit_cnt[2:0] == 3'h0;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame not whole bytes");
  property p_oe_late;
    $rose(miso_oe) |-> bit_cnt >= 16'h0018;
  endproperty
  a_oe_late: assert property (p_oe_late) else $error("miso driven in header");
endmodule : sfs_link_props
`default_nettype wire

// file: tb/test_spi_frame_slave_vdm_fdm.sv
`default_nettype none
module test_spi_frame_slave_vdm_fdm;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst;
  logic start;
  logic [15:0] addr;
  logic [4:0] bsel;
  logic rw;
  logic [1:0] mode;
  logic [2:0] nvar;
  logic [7:0] tx_data;
  logic [7:0] rd_data;
  logic tx_take;
  logic rx_valid;
  logic busy;
  logic [7:0] rx_data;
  logic [15:0] acc_addr;
  logic [4:0] t_bsel;
  logic [7:0] wr_data;
  logic wr_strobe;
  logic rd_strobe;
  logic sclk_q;
  logic [7:0] wq[$];
  logic [15:0] aq[$];
  logic [7:0] rq[$];
  logic bq[$];
  int fail_count;
  int check_count;
  sfs_link_if link ();
  sfs_host sfs_host_inst (.clk(clk), .rst(rst), .link(link), .start(start), .addr(addr),
    .block_select_bits(bsel), .read_write_bit(rw), .length_mode_bits(mode), .var_bytes(nvar),
    .tx_data(tx_data), .tx_take(tx_take), .rx_data(rx_data), .rx_valid(rx_valid), .busy(busy));
  sfs_target sfs_target_inst (.clk(clk), .rst(rst), .link(link), .acc_addr(acc_addr),
    .block_select_bits(t_bsel), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rd_data(rd_data));
  sfs_link_props sfs_link_props_inst (.clk(clk), .rst(rst), .sclk(link.sclk),
    .chip_select_n(link.chip_select_n), .mosi(link.mosi), .miso(link.miso),
    .miso_oe(link.miso_oe));
  // ------------------------------
  // user sides and wire sampling
  // ------------------------------
  always @(posedge clk)
  begin
    sclk_q <= link.sclk;
    if (tx_take) tx_data <= tx_data + 8'h11;
    // memory stand-in: byte is a function of its address
    if (rd_strobe) rd_data <= acc_addr[7:0] ^ 8'h5a;
    if (wr_strobe) wq.push_back(wr_data);
    if (wr_strobe) aq.push_back(acc_addr);
    if (rx_valid) rq.push_back(rx_data);
    if (link.sclk && !sclk_q && !link.chip_select_n) bq.push_back(link.mosi);
  end
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  task automatic run_frame(input logic [23:0] hdr, input logic [2:0] n);
    int k;
    logic [23:0] got;
    wq.delete();
    aq.delete();
    rq.delete();
    bq.delete();
    @(posedge clk);
    {addr, bsel, rw, mode} <= hdr;
    nvar <= n;
    tx_data <= 8'hc3;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    k = 0;
    while ((busy !== 1'b0 || k < 4) && k < 5000)
    begin
      @(posedge clk);
      k++;
    end
    repeat (40) @(posedge clk);
    for (int i = 0; i < 24; i++)
      got[23 - i] = bq[i];
    check(k < 5000, "frame hung");
    check(got === hdr, "header bits");
    check(bq.size() == 24 + 8 * int'(n), "sclk count");
  endtask : run_frame
  task automatic check_bytes(input logic w, input logic [15:0] a, input int n);
    check((w ? wq.size() : rq.size()) == n, "byte count");
    check(t_bsel === bsel, "block select");
    for (int i = 0; i < n; i++)
    begin
      if (w)
      begin
        check(wq[i] === 8'hc3 + 8'(i * 17), "write data");
        check(aq[i] === a + 16'(i), "write address");
      end
      else
        check(rq[i] === (8'(a + 16'(i)) ^ 8'h5a), "read data");
    end
  endtask : check_bytes
  task automatic t_var_write();
    run_frame({16'h1234, 5'h05, sfs_pkg::RW_WRITE, sfs_pkg::LEN_VAR}, 3'h3);
    check_bytes(1'b1, 16'h1234, 3);
    run_frame({16'hfffe, 5'h11, sfs_pkg::RW_WRITE, sfs_pkg::LEN_VAR}, 3'h4);
    check_bytes(1'b1, 16'hfffe, 4);
  endtask : t_var_write
  task automatic t_fixed_write();
    for (int i = 1; i < 4; i++)
    begin
      run_frame({16'h2000 + 16'(i), 5'h0a, sfs_pkg::RW_WRITE, 2'(i)}, 3'(i == 3 ? 4 : i));
      check_bytes(1'b1, 16'h2000 + 16'(i), i == 3 ? 4 : i);
    end
  endtask : t_fixed_write
  task automatic t_reads();
    run_frame({16'h00fe, 5'h1f, sfs_pkg::RW_READ, sfs_pkg::LEN_VAR}, 3'h3);
    check_bytes(1'b0, 16'h00fe, 3);
    for (int i = 1; i < 3; i++)
    begin
      run_frame({16'h3000, 5'h04, sfs_pkg::RW_READ, 2'(i)}, 3'(i));
      check_bytes(1'b0, 16'h3000, i);
    end
  endtask : t_reads
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    #(8 * 40000);
    fail_count++;
    results();
  end
  initial
  begin
    fail_count = 0;
    check_count = 0;
    rst = 1'b1;
    start = 1'b0;
    {addr, bsel, rw, mode} = 24'h00_0000;
    nvar = 3'h0;
    tx_data = 8'h00;
    rd_data = 8'h00;
    sclk_q = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_var_write();
    t_fixed_write();
    t_reads();
    results();
  end
endmodule : test_spi_frame_slave_vdm_fdm
`default_nettype wire
